// [hdl/ssc_line_filt.sv]
module ssc_line_filt (
  input  wire logic sys_clk, // System clock
  input  wire logic arst_n,  // Asynchronous reset, active low
  input  wire logic raw,     // Line level as seen on the pin
  output logic      clean    // Synchronised, deglitched level
);
  import ssc_pkg::*;

  localparam logic [1:0] RUN_MAX = 2'(FILT_LEN - 1);

  logic       meta;
  logic       sync;
  logic [1:0] run_cnt;
  logic [1:0] next_run_cnt;
  logic       next_clean;

  // Accept a new level only after it has held for several samples
  always_comb begin
    next_run_cnt = 2'h0;
    next_clean   = clean;
    if (sync != clean) begin
      if (run_cnt == RUN_MAX) begin
        next_clean = sync;
      end else begin
        next_run_cnt = run_cnt + 2'h1;
      end
    end
  end

  // Idle bus is high, so every stage resets high
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta    <= 1'b1;
      sync    <= 1'b1;
      run_cnt <= 2'h0;
      clean   <= 1'b1;
    end else begin
      meta    <= raw;
      sync    <= meta;
      run_cnt <= next_run_cnt;
      clean   <= next_clean;
    end
  end
endmodule

// [hdl/ssc_master.sv]
// Function
// - Shipping commands always carry a whole byte and its acknowledge clock; the code goes to STOP right after the acknowledge clock of a refused frame.
// - Bus clock never exceeds 400 kHz.
// - START: data falls while clock is high, made by the master only.
// - STOP: data rises while clock is high, made by the master only.
// - Each frame is eight bits plus one acknowledge clock.
// - Bits go most significant first in both directions.
// - Transmitter drives data bits; receiver drives the acknowledge bit.
// - Master opens every transaction with START and makes every clock edge.
// - Reads swap roles after the address frame; writes keep the master sending.
// - Lines rest high; data and clock are only released or pulled low.
module ssc_master (
  input  wire logic               sys_clk,   // 25 MHz system clock
  input  wire logic               arst_n,    // Asynchronous reset, active low
  input  wire logic               cmd_valid, // Command offered
  output logic                    cmd_ready, // Command taken when both high
  input  wire ssc_pkg::ssc_cmd_t  cmd,       // Operation, sub address, data
  output logic                    rsp_valid, // One-cycle pulse, transaction done
  output ssc_pkg::ssc_rsp_t       rsp,       // Refusal flag and read byte
  output logic                    scl_o,     // Clock pin drive value, always low
  output logic                    scl_oe,    // High while pulling the clock low
  input  wire logic               scl_i,     // Clock pin level
  output logic                    sda_o,     // Data pin drive value, always low
  output logic                    sda_oe,    // High while pulling data low
  input  wire logic               sda_i      // Data pin level
);
  import ssc_pkg::*;

  // ******************************************************
  // Helpers
  // ******************************************************
  // Byte sent at each frame position of a transaction
  function automatic logic [7:0] frame_byte(input ssc_cmd_t c, input logic [1:0] idx);
    logic [7:0] b;
    b = SHIP_FILL;
    if (idx == 2'd0) begin
      b = (c.op == SSC_OP_READ) ? ADDR_RD : ADDR_WR;
    end else if (idx == 2'd1) begin
      b = c.sub;
      if (c.op == SSC_OP_SHIP) begin
        b = c.data[0] ? SUB_SHIP_ARM : SUB_SHIP_DISARM;
      end
    end else if (c.op != SSC_OP_SHIP) begin
      b = c.data;
    end
    return b;
  endfunction

  // Index of the final frame; ship commands send the data byte unless an earlier frame is refused
  function automatic logic [1:0] last_idx(input ssc_op_t op);
    logic [1:0] l;
    l = 2'd1;
    if (op == SSC_OP_WRITE || op == SSC_OP_SHIP) begin
      l = 2'd2;
    end
    return l;
  endfunction

  // ******************************************************
  // Quarter-bit timebase and input filtering
  // ******************************************************
  ssc_state_t state;
  logic       tick;
  logic       sda_in;

  ssc_qtr_div u_div (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .run     (state != ST_IDLE),
    .tick    (tick)
  );

  // Clock is not filtered: the device never stretches, so it is not watched
  ssc_line_filt u_sda_filt (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .raw     (sda_i),
    .clean   (sda_in)
  );

  // ******************************************************
  // Transaction sequencer
  // ******************************************************
  ssc_state_t next_state;
  logic [1:0] q;
  logic [1:0] next_q;
  logic [3:0] bitn;
  logic [3:0] next_bitn;
  logic [1:0] bidx;
  logic [1:0] next_bidx;
  ssc_cmd_t   cur;
  ssc_cmd_t   next_cur;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic       nack;
  logic       next_nack;
  logic       scl_pull;
  logic       next_scl_pull;
  logic       sda_pull;
  logic       next_sda_pull;
  logic       next_rsp_valid;
  ssc_rsp_t   next_rsp;
  logic       rd_byte;

  assign rd_byte   = (cur.op == SSC_OP_READ) && (bidx == 2'd1);
  assign cmd_ready = (state == ST_IDLE);

  // Pin levels for quarter q+1 are set on the tick that ends quarter q
  always_comb begin
    next_state     = state;
    next_q         = q;
    next_bitn      = bitn;
    next_bidx      = bidx;
    next_cur       = cur;
    next_shreg     = shreg;
    next_nack      = nack;
    next_scl_pull  = scl_pull;
    next_sda_pull  = sda_pull;
    next_rsp_valid = 1'b0;
    next_rsp       = rsp;
    case (state)
      ST_IDLE: begin
        next_scl_pull = 1'b0;
        next_sda_pull = 1'b0;
        if (cmd_valid) begin
          next_cur   = cmd;
          next_state = ST_START;
          next_q     = 2'd0;
          next_nack  = 1'b0;
          next_bidx  = 2'd0;
        end
      end
      ST_START: begin
        if (tick) begin
          next_q = q + 2'd1;
          if (q == 2'd2) begin
            next_sda_pull = 1'b1;
          end
          if (q == 2'd3) begin
            next_state    = ST_XFER;
            next_bitn     = 4'd0;
            next_shreg    = frame_byte(cur, 2'd0);
            next_scl_pull = 1'b1;
          end
        end
      end
      ST_XFER: begin
        if (tick) begin
          next_q = q + 2'd1;
          if (q == 2'd0) begin
            // Data only moves while the clock is held low
            if (bitn < 4'd8) begin
              next_sda_pull = !rd_byte && !shreg[7];
            end else begin
              next_sda_pull = 1'b0;
            end
          end
          if (q == 2'd1) begin
            next_scl_pull = 1'b0;
          end
          if (q == 2'd3) begin
            next_scl_pull = 1'b1;
            if (bitn < 4'd8) begin
              next_shreg = {shreg[6:0], sda_in};
              next_bitn  = bitn + 4'd1;
            end else if (!rd_byte && sda_in) begin
              next_nack  = 1'b1;
              next_state = ST_STOP;
            end else if (bidx == last_idx(cur.op)) begin
              next_state = ST_STOP;
            end else begin
              next_bidx  = bidx + 2'd1;
              next_bitn  = 4'd0;
              next_shreg = frame_byte(cur, bidx + 2'd1);
            end
          end
        end
      end
      ST_STOP: begin
        if (tick) begin
          next_q = q + 2'd1;
          if (q == 2'd0) begin
            next_sda_pull = 1'b1;
          end
          if (q == 2'd1) begin
            next_scl_pull = 1'b0;
          end
          if (q == 2'd2) begin
            next_sda_pull = 1'b0;
          end
          if (q == 2'd3) begin
            next_state     = ST_IDLE;
            next_rsp_valid = 1'b1;
            next_rsp.nack  = nack;
            next_rsp.data  = (cur.op == SSC_OP_READ) ? shreg : 8'h00;
          end
        end
      end
      default: begin
        next_state    = ST_IDLE;
        next_scl_pull = 1'b0;
        next_sda_pull = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state     <= ST_IDLE;
      q         <= 2'd0;
      bitn      <= 4'd0;
      bidx      <= 2'd0;
      cur       <= '0;
      shreg     <= 8'h00;
      nack      <= 1'b0;
      scl_pull  <= 1'b0;
      sda_pull  <= 1'b0;
      rsp_valid <= 1'b0;
      rsp       <= '0;
    end else begin
      state     <= next_state;
      q         <= next_q;
      bitn      <= next_bitn;
      bidx      <= next_bidx;
      cur       <= next_cur;
      shreg     <= next_shreg;
      nack      <= next_nack;
      scl_pull  <= next_scl_pull;
      sda_pull  <= next_sda_pull;
      rsp_valid <= next_rsp_valid;
      rsp       <= next_rsp;
    end
  end

  // Open-drain: a pin is only ever pulled low or let go
  assign scl_o  = 1'b0;
  assign sda_o  = 1'b0;
  assign scl_oe = scl_pull;
  assign sda_oe = sda_pull;

  // ******************************************************
  // Checks
  // ******************************************************
  localparam int SCL_MIN_HOLD = 2 * QTR_CYC - 1;

  logic [7:0] scl_hold;
  logic [7:0] tx_byte;
  logic       tx_bit;

  // Expected bit rebuilt from the command, so a wrong shift direction is caught
  assign tx_byte = frame_byte(cur, bidx);
  assign tx_bit  = tx_byte[3'(4'd7 - bitn)];

  // Cycles since the clock drive last changed, saturating
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      scl_hold <= 8'h00;
    end else if (scl_oe != next_scl_pull) begin
      scl_hold <= 8'h00;
    end else if (scl_hold != 8'hff) begin
      scl_hold <= scl_hold + 8'h01;
    end
  end

  AST_SCL_RATE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (scl_oe != $past(scl_oe)) |-> ($past(scl_hold) >= 8'(SCL_MIN_HOLD)))
    else $error("Clock phase shorter than half a 400 kHz period");

  AST_START_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($rose(sda_oe) && !scl_oe) |-> (state == ST_START) && (q == 2'd3))
    else $error("Data fell with clock high outside a START");

  AST_STOP_ONLY: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($fell(sda_oe) && !scl_oe) |-> (state == ST_STOP) && (q == 2'd3))
    else $error("Data rose with clock high outside a STOP");

  AST_MSB_FIRST: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_XFER && tick && q == 2'd0 && bitn < 4'd8 && !rd_byte) |=> (sda_oe == !$past(tx_bit)))
    else $error("Transmitted bit is not the current most significant bit");

  AST_BIT_STEP: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_XFER && tick && q == 2'd3 && bitn < 4'd8) |=> (bitn == $past(bitn) + 4'd1) && scl_oe)
    else $error("Frame bit count did not advance by one");

  AST_ACK_RELEASE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_XFER && bitn == 4'd8 && q >= 2'd2) |-> !sda_oe)
    else $error("Data line held during the acknowledge clock");

  AST_READ_RELEASE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (state == ST_XFER && rd_byte && q >= 2'd2) |-> !sda_oe)
    else $error("Data line held while the device sends");

  AST_SHIP_WHOLE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    ($rose(state == ST_STOP) && cur.op == SSC_OP_SHIP && !nack) |-> (bidx == 2'd2) && $past(bitn == 4'd8))
    else $error("Ship command stopped before its full data byte");

  AST_OPEN_START: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (cmd_valid && cmd_ready) |=> (state == ST_START) && !scl_oe ##1 !sda_oe)
    else $error("Accepted command did not open with a START");

  AST_DONE_PULSE: assert property (@(posedge sys_clk) disable iff (!arst_n)
    rsp_valid |-> (state == ST_IDLE) && !scl_oe && !sda_oe ##1 !rsp_valid)
    else $error("Response pulse without a released bus");
endmodule

// [hdl/ssc_pkg.sv]
package ssc_pkg;
  // ******************************************************
  // Timing
  // ******************************************************
  localparam int CLK_KHZ     = 25000;                                  // System clock rate
  localparam int BUS_MAX_KHZ = 400;                                    // Fastest legal bus clock
  localparam int QTR_CYC     = (CLK_KHZ + 4 * BUS_MAX_KHZ - 1) / (4 * BUS_MAX_KHZ); // Quarter bit, rounded up
  localparam int FILT_LEN    = 3;                                      // Equal samples before a level is believed

  // ******************************************************
  // Device addresses and sub addresses
  // ******************************************************
  localparam logic [7:0] ADDR_WR         = 8'h12;
  localparam logic [7:0] ADDR_RD         = 8'h13;
  localparam logic [7:0] SUB_SHIP_ARM    = 8'h07;
  localparam logic [7:0] SUB_SHIP_DISARM = 8'h06;
  localparam logic [7:0] SHIP_FILL       = 8'h00;                      // Value is ignored by the device

  // ******************************************************
  // Types
  // ******************************************************
  typedef enum logic [1:0] {
    SSC_OP_WRITE = 2'h0,                                               // Sub address then data
    SSC_OP_POINT = 2'h1,                                               // Sub address only
    SSC_OP_READ  = 2'h2,                                               // One byte from the pointer
    SSC_OP_SHIP  = 2'h3                                                // data[0]=1 arm, 0 disarm
  } ssc_op_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_START = 4'b0010,
    ST_XFER  = 4'b0100,
    ST_STOP  = 4'b1000
  } ssc_state_t;

  typedef struct packed {
    ssc_op_t    op;
    logic [7:0] sub;
    logic [7:0] data;
  } ssc_cmd_t;

  typedef struct packed {
    logic       nack;
    logic [7:0] data;
  } ssc_rsp_t;
endpackage

// [hdl/ssc_qtr_div.sv]
module ssc_qtr_div (
  input  wire logic sys_clk, // System clock
  input  wire logic arst_n,  // Asynchronous reset, active low
  input  wire logic run,     // Count while high, hold at zero otherwise
  output logic      tick     // One-cycle pulse per quarter bit
);
  import ssc_pkg::*;

  localparam logic [4:0] LAST = 5'(QTR_CYC - 1);

  logic [4:0] cnt;
  logic [4:0] next_cnt;

  // Restart from zero so the first quarter of a transaction is full length
  always_comb begin
    next_cnt = cnt;
    if (!run || cnt == LAST) begin
      next_cnt = 5'h00;
    end else begin
      next_cnt = cnt + 5'h01;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt <= 5'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick = run && (cnt == LAST);
endmodule

// [verif/ssc_dev_model.sv]
module ssc_dev_model (
  input  wire logic sys_clk,             // Sampling clock of the line filters
  input  wire logic scl,                 // Clock line level
  input  wire logic sda,                 // Data line level
  input  wire logic serial_io_supply,    // High while the I/O supply is good
  input  wire logic input_power_rail,    // High while input power is present
  output logic      sda_pull,            // High while pulling data low
  output logic      ship_armed,          // Shipping mode armed
  output logic      battery_fet_gate_out // High drives the battery gate off
);
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  // ******************************************************
  // Behavioural serial slave with shipping mode
  // ******************************************************
  logic [2:0] hs       = 3'b111;
  logic [2:0] hd       = 3'b111;
  logic       fs       = 1'b1;
  logic       fd       = 1'b1;
  logic       ps;
  logic       pd;
  logic       armed    = 1'b0;
  logic       ship_on  = 1'b0;
  logic       pw_prev  = 1'b1;
  logic       rd_done;
  logic       odd;
  logic [1:0] mode;    // 0 idle, 1 address, 2 write, 3 read
  logic [3:0] bits;
  logic [7:0] sh;
  logic [7:0] ptr;
  logic [7:0] dirty;
  logic [7:0] pend [0:7];
  logic [7:0] act  [0:7];

  assign battery_fet_gate_out = ship_on;
  assign ship_armed           = armed;

  // Clock line is never touched, data only pulled low
  always @(posedge sys_clk) begin
    if (!serial_io_supply) begin
      mode = 2'h0; bits = 4'h0; ptr = 8'h00; odd = 1'b0; rd_done = 1'b0; dirty = 8'h00;
      for (int i = 0; i < 8; i++) begin
        pend[i] = 8'h00;
        act[i]  = 8'h00;
      end
      sda_pull <= 1'b0;
    end else begin
      ps = fs;
      pd = fd;
      hs = {hs[1:0], scl};
      hd = {hd[1:0], sda};
      // A level is believed only after three equal samples, so glitches vanish
      if (hs == 3'b111) fs = 1'b1; else if (hs == 3'b000) fs = 1'b0;
      if (hd == 3'b111) fd = 1'b1; else if (hd == 3'b000) fd = 1'b0;
      if (fs && ps && pd && !fd) begin
        mode = 2'h1; bits = 4'h0; rd_done = 1'b0;
      end else if (fs && ps && !pd && fd) begin
        for (int i = 0; i < 8; i++) if (dirty[i]) act[i] = pend[i];
        dirty = 8'h00; mode = 2'h0; sda_pull <= 1'b0;
      end else if (fs && !ps && mode != 2'h0) begin
        if (bits < 4'h8) sh = {sh[6:0], fd};
        bits = bits + 4'h1;
      end else if (!fs && ps && mode != 2'h0) begin
        if (bits == 4'h8) begin
          if (mode == 2'h1 && sh != ADDR_WR && sh != ADDR_RD) mode = 2'h0;
          sda_pull <= (mode == 2'h1 || mode == 2'h2);
        end else if (bits == 4'h9) begin
          bits = 4'h0; sda_pull <= 1'b0;
          if (mode == 2'h1) begin
            mode = sh[0] ? 2'h3 : 2'h2;
            odd  = 1'b1;
          end else if (mode == 2'h2) begin
            if (odd) ptr = sh;
            else begin
              pend[ptr[2:0]] = sh; dirty[ptr[2:0]] = 1'b1;
              if (ptr == SUB_SHIP_ARM) armed = 1'b1;
              if (ptr == SUB_SHIP_DISARM) begin
                armed = 1'b0; ship_on = 1'b0;
              end
            end
            odd = !odd;
          end else rd_done = 1'b1;
        end
        // Read path sets only rd_done and sda_pull, so a read of the arm address changes nothing
        if (mode == 2'h3 && bits < 4'h8) sda_pull <= !rd_done && !act[ptr[2:0]][4'h7 - bits];
      end
    end
    // Returning power wins over a pending arm
    if (input_power_rail && !pw_prev) begin
      ship_on = 1'b0; armed = 1'b0;
    end else if (armed && !input_power_rail) ship_on = 1'b1;
    pw_prev = input_power_rail;
  end
endmodule

// [verif/test_i2c_slave_ship_store_control.sv]
module test_i2c_slave_ship_store_control;
  timeunit 1ns;
  timeprecision 1ps;
  import ssc_pkg::*;
  // ******************************************************
  // Bench signals and wiring
  // ******************************************************
  logic     sys_clk = 1'b0;
  logic     arst_n = 1'b0;
  logic     cmd_valid = 1'b0;
  logic     serial_io_supply = 1'b0;
  logic     input_power_rail = 1'b1;
  ssc_cmd_t cmd = '0;
  ssc_rsp_t rsp;
  logic     cmd_ready, rsp_valid, scl_o, scl_oe, sda_o, sda_oe, dev_pull, armed, battery_fet_gate_out;
  logic     scl_prev = 1'b1;
  int       scl_gap = 1000;
  int       fail_count = 0;
  int       comparisons = 0;
  // Pull-ups: a released line reads high
  wire      scl_w = !scl_oe;
  wire      sda_w = !(sda_oe || dev_pull);

  always #20 sys_clk = !sys_clk;

  ssc_master uut (.sys_clk(sys_clk), .arst_n(arst_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd(cmd),
    .rsp_valid(rsp_valid), .rsp(rsp), .scl_o(scl_o), .scl_oe(scl_oe), .scl_i(scl_w), .sda_o(sda_o),
    .sda_oe(sda_oe), .sda_i(sda_w));
  ssc_dev_model dev (.sys_clk(sys_clk), .scl(scl_w), .sda(sda_w), .serial_io_supply(serial_io_supply),
    .input_power_rail(input_power_rail), .sda_pull(dev_pull), .ship_armed(armed),
    .battery_fet_gate_out(battery_fet_gate_out));

  // ******************************************************
  // Shared tasks
  // ******************************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic conclude();
    $display("Checks %0d, mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // One bus transaction; the bus must be idle again when it ends
  task automatic xact(input ssc_op_t op, input logic [7:0] sub, input logic [7:0] dat, output ssc_rsp_t r);
    int n;
    @(negedge sys_clk);
    cmd_valid = 1'b1;
    cmd = '{op: op, sub: sub, data: dat};
    n = 0;
    while (cmd_ready !== 1'b1 && n < 100) begin
      @(negedge sys_clk);
      n++;
    end
    @(negedge sys_clk);
    cmd_valid = 1'b0;
    n = 0;
    while (rsp_valid !== 1'b1 && n < 4000) begin
      @(negedge sys_clk);
      n++;
    end
    check(16'(rsp_valid), 16'h1);
    r = rsp;
    check(16'({scl_oe, sda_oe}), 16'h0);
  endtask

  // Bus clock period never shorter than 2.5 us, 62.5 cycles
  always @(posedge sys_clk) begin
    if (scl_w && !scl_prev) begin
      check(16'(scl_gap >= 63), 16'h1);
      scl_gap = 0;
    end else scl_gap = scl_gap + 1;
    scl_prev = scl_w;
  end

  // ******************************************************
  // Scenarios
  // ******************************************************
  task automatic t_write_read();
    ssc_rsp_t r;
    xact(SSC_OP_WRITE, 8'h02, 8'ha5, r);
    check(16'(r.nack), 16'h0);
    check(16'(dev.act[2]), 16'h00a5);
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'(r), 16'h00a5);
    $display("t_write_read done");
  endtask

  task automatic t_point();
    ssc_rsp_t r;
    xact(SSC_OP_WRITE, 8'h04, 8'h81, r);
    xact(SSC_OP_WRITE, 8'h02, 8'h5a, r);
    xact(SSC_OP_POINT, 8'h04, 8'h00, r);
    check(16'(r.nack), 16'h0);
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'(r), 16'h0081);
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'(r), 16'h0081);
    $display("t_point done");
  endtask

  task automatic t_ship();
    ssc_rsp_t r;
    xact(SSC_OP_SHIP, 8'h00, 8'h01, r);
    check(16'({armed, battery_fet_gate_out}), 16'h2);
    xact(SSC_OP_POINT, SUB_SHIP_ARM, 8'h00, r);
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'({armed, battery_fet_gate_out}), 16'h2);
    @(negedge sys_clk);
    input_power_rail = 1'b0;
    repeat (4) @(negedge sys_clk);
    check(16'(battery_fet_gate_out), 16'h1);
    input_power_rail = 1'b1;
    repeat (4) @(negedge sys_clk);
    check(16'(battery_fet_gate_out), 16'h0);
    input_power_rail = 1'b0;
    xact(SSC_OP_SHIP, 8'h00, 8'h01, r);
    check(16'(battery_fet_gate_out), 16'h1);
    xact(SSC_OP_SHIP, 8'h00, 8'h00, r);
    check(16'({armed, battery_fet_gate_out}), 16'h0);
    $display("t_ship done");
  endtask

  task automatic t_supply();
    ssc_rsp_t r;
    @(negedge sys_clk);
    serial_io_supply = 1'b0;
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'(r.nack), 16'h1);
    serial_io_supply = 1'b1;
    xact(SSC_OP_POINT, 8'h02, 8'h00, r);
    xact(SSC_OP_READ, 8'h00, 8'h00, r);
    check(16'(r), 16'h0000);
    $display("t_supply done");
  endtask

  // ******************************************************
  // Main sequence and watchdog
  // ******************************************************
  initial begin
    repeat (5) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    serial_io_supply = 1'b1;
    @(negedge sys_clk);
    check(16'({cmd_ready, rsp_valid, scl_oe, sda_oe, scl_o, sda_o}), 16'h20);
    t_write_read();
    t_point();
    t_ship();
    t_supply();
    conclude();
  end

  // Fifteen transactions of under 2000 cycles each fit well inside this span
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    $display("Error at %0t: run did not finish in time", $time);
    conclude();
  end
endmodule
